// *** src/tx_unpack_pkg.sv ***
// package for the transmit buffer unpacker: register map, command word fields,
// reset values and state encoding.
// assumes a 32-bit axi4-lite register bus and 32-bit host data words.
package tx_unpack_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] PKTS_OFS = 4'h8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_LEN_BIT = 1;
    localparam int STAT_CMP_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // ----------------------------------------
    // first command word fields
    // ----------------------------------------
    localparam int A_ALIGN_LSB = 24;
    localparam int A_OFS_LSB = 16;
    localparam int A_FIRST_BIT = 13;
    localparam int A_LAST_BIT = 12;
    localparam int A_SIZE_LSB = 0;
    // ----------------------------------------
    // second command word fields
    // ----------------------------------------
    localparam int B_TAG_LSB = 16;
    localparam int B_CRC_DIS_BIT = 13;
    localparam int B_PAD_DIS_BIT = 12;
    localparam int B_LEN_LSB = 0;
    localparam int LEN_W = 11;
    localparam int OFS_W = 5;
    // end alignment codes, as dword masks
    localparam logic [1:0] ALIGN_16 = 2'h1;
    localparam logic [1:0] ALIGN_32 = 2'h2;
    localparam logic [9:0] MASK_4 = 10'h000;
    localparam logic [9:0] MASK_16 = 10'h003;
    localparam logic [9:0] MASK_32 = 10'h007;
    // ----------------------------------------
    // parser states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_CMD_A = 3'b000,
        ST_CMD_B = 3'b001,
        ST_SKIP = 3'b010,
        ST_DATA = 3'b011,
        ST_FILL = 3'b100
    } unpack_state_t;
endpackage : tx_unpack_pkg

// *** src/tx_buffer_unpacker.sv ***
// transmit buffer unpacker: parses per-buffer command words from the host
// data stream and forwards only payload dwords with byte enables.
// assumes the host stream and the mac fifo side share i_sys_clk.
//
// Summary of operation
// - crc-disable bit stops frame check append
// - pad-disable bit stops short frame padding
// - pad-disable forces frame check append anyway
// - length field compared, mismatch sets error
// - data starts at third dword of buffer
// - offset low bits pick first byte lane
// - offset bits 4:2 skip whole dwords
// - trailing unused bytes are not forwarded
// - alignment filler dwords are discarded
// - any byte alignment and end length accepted
// - mac layer stores whole packet before sending
// - only partial and whole payload dwords stored
// - packet tag returned for status word
// - second command word mismatch sets error
`timescale 1ns/1ps
module tx_buffer_unpacker
    import tx_unpack_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // axi4-lite slave
    input wire logic [3:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [3:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // host transmit data words
    input wire logic [31:0] i_in_data,
    input wire logic i_in_valid,
    output logic o_in_ready,
    // payload to the mac transmit layer fifo
    output logic [31:0] o_out_data,
    output logic [3:0] o_out_be,
    output logic o_out_last,
    output logic o_out_valid,
    input wire logic i_out_ready,
    // per-packet controls for the mac transmit layer
    output logic [15:0] o_pkt_tag,
    output logic o_crc_add,
    output logic o_pad_add,
    output logic o_transmit_error_flag
);
    // ----------------------------------------
    // parser state
    // ----------------------------------------
    unpack_state_t state_q, state_d;
    logic [31:0] cmd_b_q;
    logic first_seg_q, last_seg_q, first_dw_q, ctrl_en_q;
    logic [2:0] skip_q, skip_d;
    logic [9:0] data_q, data_d, fill_q, fill_d;
    logic [3:0] first_be_q, last_be_q;
    logic [LEN_W:0] acc_q, acc_d;
    logic err_q, len_err_q, cmp_err_q;
    logic [15:0] pkt_cnt_q;
    logic take, emit, buf_done, len_bad, cmp_bad, out_valid_d;

    // command word a decode
    logic [OFS_W-1:0] a_ofs;
    logic [LEN_W-1:0] a_size, len_ref;
    logic [11:0] a_end, a_last_byte;
    logic [9:0] a_enddw, a_mask, a_paddw;
    logic [2:0] a_skip;
    assign take = o_in_ready && i_in_valid;
    assign a_ofs = i_in_data[A_OFS_LSB +: OFS_W];
    assign a_size = i_in_data[A_SIZE_LSB +: LEN_W];
    assign a_end = 12'(a_ofs) + 12'(a_size);
    assign a_last_byte = a_end - 12'h001;
    assign a_enddw = 10'((a_end + 12'h003) >> 2);
    assign a_mask = (i_in_data[A_ALIGN_LSB +: 2] == ALIGN_16) ? MASK_16 :
                    (i_in_data[A_ALIGN_LSB +: 2] == ALIGN_32) ? MASK_32 : MASK_4;
    assign a_paddw = (a_enddw + a_mask) & ~a_mask;
    assign a_skip = a_ofs[4:2];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    function automatic unpack_state_t pick(input logic [2:0] s, input logic [9:0] d, input logic [9:0] f);
        unpack_state_t r;
        r = ST_CMD_A;
        if (s != 3'h0) begin
            r = ST_SKIP;
        end else if (d != 10'h000) begin
            r = ST_DATA;
        end else if (f != 10'h000) begin
            r = ST_FILL;
        end
        return r;
    endfunction : pick
    always_comb begin
        state_d = state_q;
        skip_d = skip_q;
        data_d = data_q;
        fill_d = fill_q;
        emit = 1'b0;
        buf_done = 1'b0;
        if (take) begin
            case (state_q)
                ST_CMD_A: begin
                    state_d = ST_CMD_B;
                    // an empty buffer has no payload dword; all its offset words drain as filler,
                    // since a 29..31-byte offset spans more words than the skip counter holds
                    skip_d = (a_size == '0) ? 3'h0 : a_skip;
                    data_d = (a_size == '0) ? 10'h000 : a_enddw - 10'(a_skip);
                    fill_d = a_paddw - ((a_size == '0) ? 10'h000 : a_enddw);
                end
                ST_CMD_B: begin
                    state_d = pick(skip_d, data_d, fill_d);
                end
                ST_SKIP: begin
                    skip_d = skip_q - 3'h1;
                end
                ST_DATA: begin
                    data_d = data_q - 10'h001;
                    emit = 1'b1;
                end
                ST_FILL: begin
                    fill_d = fill_q - 10'h001;
                end
                default: begin
                    state_d = ST_CMD_A;
                end
            endcase
            if (state_q != ST_CMD_A && state_q != ST_CMD_B) begin
                state_d = pick(skip_d, data_d, fill_d);
            end
            buf_done = (state_q != ST_CMD_A) && (state_d == ST_CMD_A);
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_q <= ST_CMD_A;
            skip_q <= 3'h0;
            data_q <= 10'h000;
            fill_q <= 10'h000;
        end else begin
            state_q <= state_d;
            skip_q <= skip_d;
            data_q <= data_d;
            fill_q <= fill_d;
        end
    end

    // ----------------------------------------
    // per-buffer lane masks and segment flags
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            first_be_q <= 4'h0;
            last_be_q <= 4'h0;
            first_seg_q <= 1'b0;
            last_seg_q <= 1'b0;
            first_dw_q <= 1'b0;
        end else if (take && state_q == ST_CMD_A) begin
            first_be_q <= 4'hf << a_ofs[1:0];
            last_be_q <= 4'hf >> (2'h3 - a_last_byte[1:0]);
            first_seg_q <= i_in_data[A_FIRST_BIT];
            last_seg_q <= i_in_data[A_LAST_BIT];
            first_dw_q <= 1'b1;
        end else if (emit) begin
            first_dw_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // second command word and packet length check
    // ----------------------------------------
    assign cmp_bad = take && state_q == ST_CMD_B && !first_seg_q && (i_in_data != cmd_b_q);
    assign len_ref = (state_q == ST_CMD_B && first_seg_q) ? i_in_data[B_LEN_LSB +: LEN_W] :
                     cmd_b_q[B_LEN_LSB +: LEN_W];
    assign len_bad = buf_done && last_seg_q && (acc_q != {1'b0, len_ref});
    // a first segment restarts the running count
    assign acc_d = !(take && state_q == ST_CMD_A) ? acc_q :
                   (i_in_data[A_FIRST_BIT] ? '0 : acc_q) + {1'b0, a_size};

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cmd_b_q <= 32'h0000_0000;
            acc_q <= '0;
            o_pkt_tag <= 16'h0000;
            o_crc_add <= 1'b1;
            o_pad_add <= 1'b1;
        end else begin
            acc_q <= acc_d;
            if (take && state_q == ST_CMD_B && first_seg_q) begin
                cmd_b_q <= i_in_data;
                o_pkt_tag <= i_in_data[B_TAG_LSB +: 16];
                o_crc_add <= !i_in_data[B_CRC_DIS_BIT] || i_in_data[B_PAD_DIS_BIT];
                o_pad_add <= !i_in_data[B_PAD_DIS_BIT];
            end
        end
    end

    // ----------------------------------------
    // output word register toward the mac fifo
    // ----------------------------------------
    // ready is registered, so payload moves at half rate; the trade keeps every port on a flop
    assign out_valid_d = (o_out_valid && !i_out_ready) || emit;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_out_valid <= 1'b0;
            o_out_data <= 32'h0000_0000;
            o_out_be <= 4'h0;
            o_out_last <= 1'b0;
            o_in_ready <= 1'b0;
        end else begin
            o_out_valid <= out_valid_d;
            o_in_ready <= ctrl_en_q && !out_valid_d;
            if (emit) begin
                o_out_data <= i_in_data;
                o_out_be <= (first_dw_q ? first_be_q : 4'hf) & ((data_q == 10'h001) ? last_be_q : 4'hf);
                o_out_last <= (data_q == 10'h001) && last_seg_q;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic aw_full_q, w_full_q, wr_go, wr_ctrl, wr_stat;
    logic [3:0] aw_addr_q, w_strb_q;
    logic [31:0] w_data_q;
    assign wr_go = aw_full_q && w_full_q && !o_bvalid;
    assign wr_ctrl = wr_go && aw_addr_q == CTRL_OFS && w_strb_q[0];
    assign wr_stat = wr_go && aw_addr_q == STAT_OFS && w_strb_q[0];

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else begin
            o_awready <= !aw_full_q && !(o_awready && i_awvalid);
            o_wready <= !w_full_q && !(o_wready && i_wvalid);
            if (o_awready && i_awvalid) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {i_awaddr[3:2], 2'h0};
            end
            if (o_wready && i_wvalid) begin
                w_full_q <= 1'b1;
                w_data_q <= i_wdata;
                w_strb_q <= i_wstrb;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (aw_addr_q == CTRL_OFS || aw_addr_q == STAT_OFS || aw_addr_q == PKTS_OFS) ?
                           RESP_OKAY : RESP_DECERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ctrl_en_q <= CTRL_RST[CTRL_EN_BIT];
        end else if (wr_ctrl) begin
            ctrl_en_q <= w_data_q[CTRL_EN_BIT];
        end
    end

    // error flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            err_q <= 1'b0;
            len_err_q <= 1'b0;
            cmp_err_q <= 1'b0;
            o_transmit_error_flag <= 1'b0;
            pkt_cnt_q <= 16'h0000;
        end else begin
            len_err_q <= len_bad || (len_err_q && !(wr_stat && w_data_q[STAT_LEN_BIT]));
            cmp_err_q <= cmp_bad || (cmp_err_q && !(wr_stat && w_data_q[STAT_CMP_BIT]));
            err_q <= len_bad || cmp_bad || (err_q && !(wr_stat && w_data_q[STAT_ERR_BIT]));
            o_transmit_error_flag <= len_bad || cmp_bad || (err_q && !(wr_stat && w_data_q[STAT_ERR_BIT]));
            if (buf_done && last_seg_q) begin
                pkt_cnt_q <= pkt_cnt_q + 16'h0001;
            end
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else begin
            o_arready <= !o_rvalid && !(o_arready && i_arvalid);
            if (o_arready && i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rresp <= RESP_OKAY;
                case ({i_araddr[3:2], 2'h0})
                    CTRL_OFS: o_rdata <= 32'(ctrl_en_q);
                    STAT_OFS: o_rdata <= 32'({state_q != ST_CMD_A, cmp_err_q, len_err_q, err_q});
                    PKTS_OFS: o_rdata <= 32'(pkt_cnt_q);
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= RESP_DECERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule : tx_buffer_unpacker

// *** dv/tx_buffer_unpacker_properties.sv ***
// checker for the transmit buffer unpacker, watching its ports only
// assumes it is bound onto every tx_buffer_unpacker instance
`timescale 1ns/1ps
module unpack_props (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // register bus
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    // data stream
    input wire logic o_in_ready,
    input wire logic [31:0] o_out_data,
    input wire logic [3:0] o_out_be,
    input wire logic o_out_last,
    input wire logic o_out_valid,
    input wire logic i_out_ready,
    // packet controls
    input wire logic [15:0] o_pkt_tag,
    input wire logic o_crc_add,
    input wire logic o_pad_add,
    input wire logic o_transmit_error_flag
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    crc_forced_a: assert property (!o_pad_add |-> o_crc_add)
        else $error("frame check dropped with padding off");
    lanes_contig_a: assert property (o_out_valid |-> o_out_be inside {4'h1, 4'h3, 4'h7, 4'hf,
        4'h2, 4'h6, 4'he, 4'h4, 4'hc, 4'h8}) else $error("byte enables not contiguous");
    no_empty_a: assert property (o_out_valid |-> o_out_be != 4'h0)
        else $error("empty dword forwarded");
    out_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data)
        && $stable(o_out_be) && $stable(o_out_last)) else $error("payload changed while stalled");
    slot_busy_a: assert property ($rose(o_out_valid) |-> !o_in_ready)
        else $error("input taken with output slot full");
    tag_hold_a: assert property (o_out_valid && !i_out_ready |=> $stable(o_pkt_tag))
        else $error("tag changed mid packet");
    ctl_hold_a: assert property (o_out_valid && !i_out_ready |=> $stable(o_crc_add) && $stable(o_pad_add))
        else $error("frame controls changed mid packet");
    err_sticky_a: assert property (o_transmit_error_flag && o_awready && !i_awvalid && !i_wvalid
        |=> o_transmit_error_flag) else $error("error flag cleared without a write");
endmodule : unpack_props

bind tx_buffer_unpacker unpack_props chk (.i_sys_clk, .i_rst_n, .i_awvalid, .o_awready, .i_wvalid,
    .o_in_ready, .o_out_data, .o_out_be, .o_out_last, .o_out_valid, .i_out_ready, .o_pkt_tag,
    .o_crc_add, .o_pad_add, .o_transmit_error_flag);

// *** dv/host_word_source.sv ***
// host driver model: hands queued dwords to the unpacker, one per handshake
// assumes the unpacker's clock and synchronous active-low reset
`timescale 1ns/1ps
module host_word_source (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // one idle cycle after each word when set
    input wire logic i_slow,
    // dword stream
    output logic [31:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    logic [31:0] q [$];
    // the bench builds buffers with zeroed reserved bits and end filler
    // middle buffers stay at 4 bytes or more, packets few and small
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_data <= 32'h0;
        end else if (!o_valid || i_ready) begin
            if (o_valid) void'(q.pop_front());
            if (q.size() != 0 && !(o_valid && i_slow)) begin
                o_valid <= 1'b1;
                o_data <= q[0];
            end else begin
                // idle data keeps moving so a stale word is never mistaken for valid
                o_valid <= 1'b0;
                o_data <= ~o_data;
            end
        end
    end
endmodule : host_word_source

// *** dv/testbench.sv ***
// bench for the transmit buffer unpacker: register bus tasks and buffer scenarios
// assumes the host word source model and the bound checker
`timescale 1ns/1ps
module testbench;
    import tx_unpack_pkg::*;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0, i_out_ready = 1'b0, slow = 1'b0, i_in_valid;
    logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, o_out_be;
    logic [31:0] i_wdata = 32'h0, i_in_data, o_rdata, o_out_data, q;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_in_ready, o_out_last, o_out_valid;
    logic o_crc_add, o_pad_add, o_transmit_error_flag;
    logic [1:0] o_bresp, o_rresp, r;
    logic [15:0] o_pkt_tag;
    logic [7:0] seq = 8'h00;
    logic [7:0] exp_q [$], got_q [$];
    int lasts = 0, failures = 0, tests_run = 0, cyc = 0;
    tx_buffer_unpacker uut (.i_sys_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb(4'hf), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_in_data, .i_in_valid, .o_in_ready,
        .o_out_data, .o_out_be, .o_out_last, .o_out_valid, .i_out_ready, .o_pkt_tag, .o_crc_add,
        .o_pad_add, .o_transmit_error_flag);
    host_word_source host (.i_clk(i_sys_clk), .i_rst_n, .i_slow(slow), .o_data(i_in_data),
        .o_valid(i_in_valid), .i_ready(o_in_ready));
    initial forever #10 i_sys_clk = ~i_sys_clk;
    // mac side stalls one cycle in four; also the run's cycle ceiling
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        i_out_ready <= cyc[1:0] != 2'h0;
        if (o_out_valid && i_out_ready) begin
            for (int i = 0; i < 4; i++) if (o_out_be[i]) got_q.push_back(o_out_data[8*i +: 8]);
            if (o_out_last) lasts++;
        end
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
        if (wr) begin
            i_awaddr <= a;
            i_wdata <= d;
            i_awvalid <= 1'b1;
            i_wvalid <= 1'b1;
            i_bready <= 1'b1;
        end else begin
            i_araddr <= a;
            i_arvalid <= 1'b1;
            i_rready <= 1'b1;
        end
        do begin
            @(posedge i_sys_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_arready) i_arvalid <= 1'b0;
        end while (!(wr ? o_bvalid : o_rvalid));
        q = o_rdata;
        r = wr ? o_bresp : o_rresp;
        i_bready <= 1'b0;
        i_rready <= 1'b0;
        // one edge passes so a following call never reassigns these in this time step
        @(posedge i_sys_clk);
    endtask : axi
    task automatic send(input logic fs, input logic ls, input int ofs, input int size, input int al,
                        input logic [31:0] b);
        logic [7:0] by [$];
        for (int i = 0; i < ofs; i++) by.push_back(8'h5a);
        for (int i = 0; i < size; i++) begin
            by.push_back(seq);
            exp_q.push_back(seq);
            seq++;
        end
        while (by.size() % (al == 2 ? 32 : al == 1 ? 16 : 4) != 0) by.push_back(8'ha5);
        host.q.push_back({6'h0, al[1:0], 3'h0, ofs[4:0], 2'h0, fs, ls, 1'b0, size[10:0]});
        host.q.push_back(b);
        for (int i = 0; i < by.size(); i += 4) host.q.push_back({by[i+3], by[i+2], by[i+1], by[i]});
    endtask : send
    task automatic drain_check();
        while (host.q.size() != 0) @(posedge i_sys_clk);
        repeat (4) @(posedge i_sys_clk);
        while (o_out_valid) @(posedge i_sys_clk);
        check(got_q.size(), exp_q.size());
        foreach (exp_q[i]) check(got_q[i], exp_q[i]);
        check(lasts, 1);
        got_q.delete();
        exp_q.delete();
        lasts = 0;
        $display("packet test done, %0d compares so far", tests_run);
    endtask : drain_check
    task automatic test_done();
        $display("compares %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    initial begin
        int ofs [5] = '{2, 1, 3, 29, 0};
        int sz [5] = '{5, 7, 9, 6, 1};
        int al [5] = '{0, 1, 2, 2, 0};
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        axi(1'b0, CTRL_OFS, 32'h0);
        check(q, CTRL_RST);
        axi(1'b0, 4'hc, 32'h0);
        check(r, RESP_DECERR);
        axi(1'b1, 4'hc, 32'h0);
        check(r, RESP_DECERR);
        // every lane offset, whole-dword skip, each alignment and crc/pad code
        for (int k = 0; k < 5; k++) begin
            send(1'b1, 1'b1, ofs[k], sz[k], al[k], {16'h1230 + k[15:0], 2'h0, k[1], k[0], 1'b0, sz[k][10:0]});
            drain_check();
            check(o_pkt_tag, 16'h1230 + k[15:0]);
            check(o_crc_add, !k[1] || k[0]);
            check(o_pad_add, !k[0]);
        end
        slow <= 1'b1;
        send(1'b1, 1'b0, 7, 79, 1, 32'h00aa_006f);
        send(1'b0, 1'b0, 0, 15, 1, 32'h00aa_006f);
        send(1'b0, 1'b1, 10, 17, 1, 32'h00aa_006f);
        drain_check();
        slow <= 1'b0;
        axi(1'b0, STAT_OFS, 32'h0);
        check(q & 32'h7, 32'h0);
        axi(1'b0, PKTS_OFS, 32'h0);
        check(q & 32'hffff, 32'h6);
        send(1'b1, 1'b1, 1, 8, 0, 32'h0001_0009);
        drain_check();
        axi(1'b0, STAT_OFS, 32'h0);
        check(q & 32'h7, 32'h3);
        check(o_transmit_error_flag, 1'b1);
        axi(1'b1, STAT_OFS, 32'h7);
        axi(1'b0, STAT_OFS, 32'h0);
        check(q & 32'h7, 32'h0);
        send(1'b1, 1'b0, 0, 4, 0, 32'h0002_0008);
        send(1'b0, 1'b1, 3, 4, 0, 32'h0003_0008);
        drain_check();
        axi(1'b0, STAT_OFS, 32'h0);
        check(q & 32'h5, 32'h5);
        // empty first buffer whose 30-byte offset spans eight words, then its tail
        send(1'b1, 1'b0, 30, 0, 0, 32'h0004_0005);
        send(1'b0, 1'b1, 1, 5, 0, 32'h0004_0005);
        drain_check();
        // a single buffer with no payload at all ends on its own word b
        send(1'b1, 1'b1, 0, 0, 0, 32'h0005_0000);
        while (host.q.size() != 0) @(posedge i_sys_clk);
        repeat (4) @(posedge i_sys_clk);
        axi(1'b0, STAT_OFS, 32'h0);
        check(q & 32'h2, 32'h0);
        axi(1'b0, PKTS_OFS, 32'h0);
        check(q & 32'hffff, 32'ha);
        $display("register test done");
        test_done();
    end
endmodule : testbench
